//--- design/pwm_defines.svh
/*
 * Constants for the pulse width and period measurement block.
 * Assumes inclusion by bare name from design files.
 */
`ifndef PWM_DEFINES_SVH
`define PWM_DEFINES_SVH

// Measurement type encodings
`define PWM_TYPE_HIGH   2'h0
`define PWM_TYPE_LOW    2'h1
`define PWM_TYPE_PERR   2'h2
`define PWM_TYPE_PERF   2'h3
`define PWM_TYPE_RESET  2'h2

// Widths
`define PWM_CNT_W       32

`endif

//--- design/pwm_pkg.sv
/*
 * Types for the pulse width and period measurement block.
 * Assumes the defines header is available on the include path.
 */
`include "pwm_defines.svh"

package pwm_pkg;

    // Measurement selection
    typedef enum logic [1:0] {
        PWM_HIGH = `PWM_TYPE_HIGH,
        PWM_LOW  = `PWM_TYPE_LOW,
        PWM_PERR = `PWM_TYPE_PERR,
        PWM_PERF = `PWM_TYPE_PERF
    } pwm_type_t;

    // Configuration carried together
    typedef struct packed {
        pwm_type_t measType;
        logic      useTimebase;
    } pwm_cfg_t;

    // Edge events of one input: the measured input or the count source
    typedef struct packed {
        logic rise;
        logic fall;
    } pwm_edges_t;

endpackage

//--- design/pwm_edge_detect.sv
/*
 * Edge detector for one synchronous input.
 * Assumes the input is already synchronous to mclk.
 */
`timescale 1ns/1ps

module pwm_edge_detect (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               sigIn,
    output pwm_pkg::pwm_edges_t     edges
);

    logic prev_q;

    // Previous level; follows the pin in reset so release gives no false edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            prev_q <= sigIn;
        end else begin
            prev_q <= sigIn;
        end
    end

    // Edge decode
    wire logic riseHit = sigIn & ~prev_q;
    wire logic fallHit = ~sigIn & prev_q;
    assign edges = '{rise: riseHit, fall: fallHit};

endmodule

//--- design/pwm_measure.sv
/*
 * Pulse width and period measurement counter.
 * Assumes measured and source pins are synchronous to mclk, and that
 * the internal timebase arrives as a one-cycle tick pulse.
 */
`timescale 1ns/1ps
`include "pwm_defines.svh"

// Summary of operation
// (R1) Measured input pin is the signal whose width or period is found.
// (R2) Type 0 counts rising to next falling edge: high width.
// (R3) Type 1 counts falling to next rising edge: low width.
// (R4) Type 2 counts between rising edges; default after reset.
// (R5) A type measures period between successive falling edges.
// (R6) Falling-edge period uses encoding 3.
// (R7) Positive timebase selected: count internal timebase ticks.
// (R8) Timebase off: count rising edges of the count source pin.
// (R9) Same counter counts either source edges or timebase ticks.
// (R10) Finished count is held for software to read.
module pwm_measure #(
    parameter int CNT_W = `PWM_CNT_W
) (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               enable,
    input  wire pwm_pkg::pwm_cfg_t  cfg,
    input  wire logic               timebaseTick,
    input  wire logic               measured_input_pin,
    input  wire logic               count_source_pin,
    output logic [CNT_W-1:0]        result,
    output logic                    resultValid,
    output logic                    busy
);

    // ----------------------------------------
    // State and storage
    // ----------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_COUNT} pwm_state_t;

    pwm_state_t         state_q;
    pwm_state_t         state_d;
    logic [CNT_W-1:0]   count_q;
    logic [CNT_W-1:0]   result_q;
    logic               valid_q;
    pwm_pkg::pwm_type_t type_q;
    logic               useTb_q;
    logic               busy_q;

    pwm_pkg::pwm_edges_t gateEdges;
    pwm_pkg::pwm_edges_t srcEdges;

    // ----------------------------------------
    // Edge detection
    // ----------------------------------------
    pwm_edge_detect uGate (
        .mclk   (mclk),
        .rst    (rst),
        .sigIn  (measured_input_pin),
        .edges  (gateEdges)
    );

    pwm_edge_detect uSrc (
        .mclk   (mclk),
        .rst    (rst),
        .sigIn  (count_source_pin),
        .edges  (srcEdges)
    );

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // Start edge per measurement type
    function automatic logic startEdge(input pwm_pkg::pwm_type_t t,
                                       input pwm_pkg::pwm_edges_t e);
        unique case (t)
            pwm_pkg::PWM_HIGH: startEdge = e.rise; // R2
            pwm_pkg::PWM_LOW:  startEdge = e.fall; // R3
            pwm_pkg::PWM_PERR: startEdge = e.rise; // R4
            pwm_pkg::PWM_PERF: startEdge = e.fall; // R5 R6
        endcase
    endfunction

    // Stop edge per measurement type
    function automatic logic stopEdge(input pwm_pkg::pwm_type_t t,
                                      input pwm_pkg::pwm_edges_t e);
        unique case (t)
            pwm_pkg::PWM_HIGH: stopEdge = e.fall; // R2
            pwm_pkg::PWM_LOW:  stopEdge = e.rise; // R3
            pwm_pkg::PWM_PERR: stopEdge = e.rise; // R4
            pwm_pkg::PWM_PERF: stopEdge = e.fall; // R5 R6
        endcase
    endfunction

    wire logic startHit = startEdge(type_q, gateEdges); // R1
    wire logic stopHit  = stopEdge(type_q, gateEdges);  // R1
    // Tick selection: timebase or source edges
    wire logic tick     = useTb_q ? timebaseTick : srcEdges.rise; // R7 R8 R9
    wire logic [CNT_W-1:0] countInc = count_q + {{(CNT_W-1){1'b0}}, tick};

    // Next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:  if (enable) state_d = ST_ARM;
            ST_ARM:   if (!enable) state_d = ST_IDLE;
                      else if (startHit) state_d = ST_COUNT;
            ST_COUNT: if (!enable) state_d = ST_IDLE;
                      else if (stopHit) state_d = ST_ARM;
            default:  state_d = ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Config latched while idle, so a change cannot corrupt a measurement
    always_ff @(posedge mclk) begin
        if (rst) begin
            type_q  <= pwm_pkg::pwm_type_t'(`PWM_TYPE_RESET); // R4
            useTb_q <= 1'b0; // R8
        end else if (state_q == ST_IDLE) begin
            type_q  <= cfg.measType;
            useTb_q <= cfg.useTimebase;
        end
    end

    // Counter and held result
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q  <= ST_IDLE;
            count_q  <= '0;
            result_q <= '0;
            valid_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_COUNT && stopHit && enable) begin
                result_q <= count_q; // R10
                valid_q  <= 1'b1;    // R10
            end else if (state_q == ST_IDLE && enable) begin
                valid_q  <= 1'b0;
            end
            if (state_q != ST_COUNT) begin
                count_q <= '0;
            end else begin
                count_q <= countInc; // R7 R8
            end
            if (state_q == ST_COUNT && stopHit) begin
                count_q <= '0;
            end
        end
    end

    // Busy registered so the output comes straight from a flop
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_d == ST_COUNT); // R1
        end
    end

    assign result      = result_q;
    assign resultValid = valid_q;
    assign busy        = busy_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    reset_type_a: assert property (@(posedge mclk) $fell(rst) |-> // R4
        type_q == pwm_pkg::PWM_PERR)
        else $error("type not default after reset");

    high_start_a: assert property (@(posedge mclk) disable iff (rst) // R2
        (state_q == ST_ARM && enable && type_q == pwm_pkg::PWM_HIGH
         && gateEdges.rise) |=> state_q == ST_COUNT)
        else $error("high width did not start on rise");

    low_start_a: assert property (@(posedge mclk) disable iff (rst) // R3
        (state_q == ST_ARM && enable && type_q == pwm_pkg::PWM_LOW
         && gateEdges.fall) |=> state_q == ST_COUNT)
        else $error("low width did not start on fall");

    perr_stop_a: assert property (@(posedge mclk) disable iff (rst) // R4
        (state_q == ST_COUNT && enable && type_q == pwm_pkg::PWM_PERR
         && gateEdges.rise) |=> resultValid && state_q == ST_ARM)
        else $error("rise period not closed on rise");

    perf_stop_a: assert property (@(posedge mclk) disable iff (rst) // R5 R6
        (state_q == ST_COUNT && enable && type_q == pwm_pkg::PWM_PERF
         && gateEdges.fall) |=> resultValid)
        else $error("fall period not closed on fall");

    tb_count_a: assert property (@(posedge mclk) disable iff (rst) // R7
        (state_q == ST_COUNT && useTb_q && !stopHit && enable)
        |=> count_q == $past(count_q) + CNT_W'($past(timebaseTick)))
        else $error("timebase tick not counted");

    src_count_a: assert property (@(posedge mclk) disable iff (rst) // R8 R9
        (state_q == ST_COUNT && !useTb_q && !stopHit && enable)
        |=> count_q == $past(count_q) + CNT_W'($past(srcEdges.rise)))
        else $error("source edge not counted");

    result_hold_a: assert property (@(posedge mclk) disable iff (rst) // R10
        (state_q == ST_COUNT && stopHit && enable) |=>
        result == $past(count_q) ##1 result == $past(result))
        else $error("result not captured or held");

    abort_idle_a: assert property (@(posedge mclk) disable iff (rst) // R1
        (state_q != ST_IDLE && !enable) |=> state_q == ST_IDLE && !busy)
        else $error("enable low did not return to idle");

    valid_clear_a: assert property (@(posedge mclk) disable iff (rst) // R10
        (state_q == ST_IDLE && enable) |=> !resultValid && state_q == ST_ARM)
        else $error("valid not cleared on arming");

    cfg_locked_a: assert property (@(posedge mclk) disable iff (rst) // R1
        (state_q != ST_IDLE) |=> $stable(type_q) && $stable(useTb_q))
        else $error("configuration changed during a measurement");

    busy_state_a: assert property (@(posedge mclk) disable iff (rst) // R1
        busy == (state_q == ST_COUNT))
        else $error("busy does not match counting state");

endmodule

//--- verification/pwm_ttl_model.sv
/* Model of the measured TTL signal, count source and timebase ticks.
   Assumes a free-running mclk; outputs move 1 ns after its rising edge. */
`timescale 1ns/1ps

module pwm_ttl_model (
    input  wire logic       mclk,
    input  wire logic [3:0] hiOct,
    input  wire logic [3:0] loOct,
    output logic            gate,
    output logic            src,
    output logic            tick
);
    logic [7:0] phase = 8'h00;
    logic [7:0] perLen;

    // Gate edges on multiples of 8, far from source and tick pulses
    assign perLen = ({4'h0, hiOct} + {4'h0, loOct}) << 3;
    assign gate = phase < {1'h0, hiOct, 3'h0};
    assign src = phase[2];
    assign tick = phase[1:0] == 2'h2;

    // Phase counter sets high and low lengths in steps of 8 cycles
    always @(posedge mclk) begin
        phase <= #1 (phase + 8'h01 >= perLen) ? 8'h00 : phase + 8'h01;
    end
endmodule

//--- verification/tb_pwm_measure.sv
/* Self-checking bench for the width and period measurement counter.
   Assumes the TTL model file and the design files are compiled first. */
`timescale 1ns/1ps

module tb_pwm_measure;
    logic              mclk;
    logic              rst;
    logic              enable;
    pwm_pkg::pwm_cfg_t cfg;
    logic [3:0]        hiOct;
    logic [3:0]        loOct;
    logic              gate;
    logic              src;
    logic              tick;
    logic [31:0]       result;
    logic              resultValid;
    logic              busy;
    int                bad_count;
    int                n_checks;

    pwm_measure #(.CNT_W(32)) pwm_measure_i (.mclk(mclk), .rst(rst), .enable(enable),
        .cfg(cfg), .timebaseTick(tick), .measured_input_pin(gate),
        .count_source_pin(src), .result(result), .resultValid(resultValid), .busy(busy));
    pwm_ttl_model pwm_ttl_model_i (.mclk(mclk), .hiOct(hiOct), .loOct(loOct),
        .gate(gate), .src(src), .tick(tick));

    // Clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Wait for completion, noting whether busy was seen
    task automatic wait_done(output logic sawBusy);
        sawBusy = 1'b0;
        for (int i = 0; i < 600 && resultValid !== 1'b1; i++) begin
            cyc(1);
            sawBusy |= (busy === 1'b1);
        end
        check("done", {31'h0, resultValid}, 32'h1);
    endtask

    task automatic arm(input int ty, input logic useTb);
        enable = 1'b0;
        cfg = '{pwm_pkg::pwm_type_t'(ty[1:0]), useTb};
        cyc(2);
        enable = 1'b1;
        cyc(2);
    endtask

    task automatic t_reset();
        check("reset result", result, 32'h0);
        check("reset valid", {31'h0, resultValid}, 32'h0);
        check("reset busy", {31'h0, busy}, 32'h0);
    endtask

    // Every type, with source edges and with timebase ticks
    task automatic t_modes();
        logic        sawBusy;
        logic [31:0] e;
        for (int k = 0; k < 8; k++) begin
            arm(k, k[2]);
            wait_done(sawBusy);
            e = (k[1:0] == 2'h0) ? 32'h3 : (k[1:0] == 2'h1) ? 32'h5 : 32'h8;
            check("result", result, k[2] ? e << 1 : e);
            check("busy seen", {31'h0, sawBusy}, 32'h1);
            check("busy at end", {31'h0, busy}, 32'h0);
        end
    endtask

    // Idle edges ignored, count kept until next completion
    task automatic t_hold();
        logic sawBusy;
        enable = 1'b0;
        for (int i = 0; i < 80; i++) begin
            cyc(1);
            check("idle busy", {31'h0, busy}, 32'h0);
        end
        check("held result", result, 32'h10);
        hiOct = 4'h2;
        arm(0, 1'b0);
        check("result while armed", result, 32'h10);
        wait_done(sawBusy);
        check("new result", result, 32'h2);
    endtask

    // Type change while running is ignored
    task automatic t_locked();
        logic sawBusy;
        arm(2, 1'b1);
        cfg = '{pwm_pkg::PWM_HIGH, 1'b0};
        wait_done(sawBusy);
        check("locked result", result, 32'he);
    endtask

    // Enable dropped mid-count discards it; a reset while idle afterwards clears the held result
    task automatic t_abort();
        arm(2, 1'b0);
        for (int i = 0; i < 200 && busy !== 1'b1; i++) begin
            cyc(1);
        end
        check("abort started", {31'h0, busy}, 32'h1);
        cyc(3);
        enable = 1'b0;
        cyc(2);
        check("abort busy", {31'h0, busy}, 32'h0);
        check("abort valid", {31'h0, resultValid}, 32'h0);
        check("abort result", result, 32'he);
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(1);
        check("reset again result", result, 32'h0);
        check("reset again valid", {31'h0, resultValid}, 32'h0);
    endtask

    task automatic end_sim();
        if (bad_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog
    initial begin
        #800000;
        bad_count++;
        end_sim();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        enable = 1'b0;
        cfg = '{pwm_pkg::PWM_PERR, 1'b0};
        hiOct = 4'h3;
        loOct = 4'h5;
        bad_count = 0;
        n_checks = 0;
        cyc(10);
        rst = 1'b0;
        cyc(1);
        t_reset();
        t_modes();
        t_hold();
        t_locked();
        t_abort();
        end_sim();
    end
endmodule
